/* rtl/rvbf_defs.svh */
// constants of the reset vector boot fetch block
// assumes a 32-bit byte-addressed flash read port
`ifndef RVBF_DEFS_SVH
`define RVBF_DEFS_SVH
`define RVBF_BOOT_BASE     32'h0000_0000
`define RVBF_SP_OFFSET     32'h0000_0000
`define RVBF_PC_OFFSET     32'h0000_0004
`define RVBF_VTOR_RESET    32'h0000_0000
`define RVBF_VTOR_ALIGN    32'hFFFF_FF80
`define RVBF_SRAM_BASE     32'h2000_0000
`define RVBF_SRAM_MASK     32'hF000_0000
`endif

/* rtl/rvbf_pkg.sv */
// types of the reset vector boot fetch block
// assumes rvbf_defs.svh is on the include path
package rvbf_pkg;
    typedef enum logic [2:0]
    {
        RVBF_ST_IDLE  = 3'b000,
        RVBF_ST_SP_RQ = 3'b001,
        RVBF_ST_SP_WT = 3'b010,
        RVBF_ST_PC_RQ = 3'b011,
        RVBF_ST_PC_WT = 3'b100,
        RVBF_ST_RUN   = 3'b101
    } rvbf_state_t;

    typedef struct packed
    {
        logic        valid;
        logic [31:0] addr;
    } rvbf_req_t;

    typedef struct packed
    {
        logic        valid;
        logic [31:0] data;
    } rvbf_rsp_t;

    typedef struct packed
    {
        logic        start;
        logic [31:0] pc;
        logic [31:0] sp;
    } rvbf_boot_t;
endpackage : rvbf_pkg

/* rtl/rvbf_vtor.sv */
// vector table base holder
// assumes writes come from core logic on ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "rvbf_defs.svh"
module rvbf_vtor
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        boot_done,
    input  wire logic        wr_en,
    input  wire logic [31:0] wr_base,
    output logic      [31:0] base
);
    logic [31:0] base_q;
    logic [31:0] base_d;

    always_comb
    begin
        base_d = base_q;
        // relocation only honoured once boot completed
        if (boot_done && wr_en)
        begin
            base_d = wr_base & `RVBF_VTOR_ALIGN;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            base_q <= `RVBF_VTOR_RESET;
        end
        else
        begin
            base_q <= base_d;
        end
    end

    assign base = base_q;

    chk_vtor_locked_boot : assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !boot_done |=> base_q == $past(base_q))
        else $error("vector base moved before boot completed");
endmodule : rvbf_vtor
`default_nettype wire

/* rtl/rvbf_top.sv */
// reset vector boot fetch: reads sp and pc from flash after reset
// assumes a flash read port answering rsp.valid one or more cycles later
//
// Notes on behaviour
// - after reset read word at vector offset zero into stack pointer.
// - after reset read word at vector offset four as program counter.
// - boot vector reads always address internal flash from base zero.
// - vector base may move to SRAM only after boot completed.
// - execution always starts from internal flash, never another source.
// - once both fetched, branch to fetched pc and start execution.
`timescale 1ns/1ps
`default_nettype none
`include "rvbf_defs.svh"
module rvbf_top
(
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    output rvbf_pkg::rvbf_req_t     flash_req,
    input  wire rvbf_pkg::rvbf_rsp_t flash_rsp,
    input  wire logic               vtor_wr_en,
    input  wire logic [31:0]        vtor_wr_base,
    output logic      [31:0]        vtor_base,
    output rvbf_pkg::rvbf_boot_t    boot,
    output logic                    boot_done
);
    import rvbf_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    rvbf_state_t state_q;
    rvbf_state_t state_d;
    logic [31:0] sp_q;
    logic [31:0] sp_d;
    logic [31:0] pc_q;
    logic [31:0] pc_d;
    logic        start_q;
    logic        start_d;
    // fetch address is registered so the flash port sees a clean word
    logic [31:0] addr_q;
    logic [31:0] addr_d;

    function automatic logic [31:0] boot_addr(input logic [31:0] off);
        // boot base is hard wired; relocated base is never used here
        boot_addr = `RVBF_BOOT_BASE + off;
    endfunction : boot_addr

    // ------------------------------------------------------------
    // fetch sequence
    // ------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        sp_d    = sp_q;
        pc_d    = pc_q;
        start_d = 1'b0;
        addr_d  = addr_q;
        case (state_q)
            RVBF_ST_IDLE:
            begin
                addr_d  = boot_addr(`RVBF_SP_OFFSET);
                state_d = RVBF_ST_SP_RQ;
            end
            RVBF_ST_SP_RQ:
            begin
                state_d = RVBF_ST_SP_WT;
            end
            RVBF_ST_SP_WT:
            begin
                if (flash_rsp.valid)
                begin
                    sp_d    = flash_rsp.data;
                    addr_d  = boot_addr(`RVBF_PC_OFFSET);
                    state_d = RVBF_ST_PC_RQ;
                end
            end
            RVBF_ST_PC_RQ:
            begin
                state_d = RVBF_ST_PC_WT;
            end
            RVBF_ST_PC_WT:
            begin
                if (flash_rsp.valid)
                begin
                    pc_d    = flash_rsp.data;
                    start_d = 1'b1;
                    state_d = RVBF_ST_RUN;
                end
            end
            RVBF_ST_RUN:
            begin
                state_d = RVBF_ST_RUN;
            end
            default:
            begin
                state_d = RVBF_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= RVBF_ST_IDLE;
            sp_q    <= 32'h0000_0000;
            pc_q    <= 32'h0000_0000;
            start_q <= 1'b0;
            addr_q  <= `RVBF_BOOT_BASE + `RVBF_SP_OFFSET;
        end
        else
        begin
            state_q <= state_d;
            sp_q    <= sp_d;
            pc_q    <= pc_d;
            start_q <= start_d;
            addr_q  <= addr_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb
    begin
        flash_req.valid = 1'b0;
        flash_req.addr  = addr_q;
        if (state_q == RVBF_ST_SP_RQ)
        begin
            flash_req.valid = 1'b1;
        end
        else if (state_q == RVBF_ST_PC_RQ)
        begin
            flash_req.valid = 1'b1;
        end
    end

    // pc handed on as fetched; flash is the only boot source
    assign boot.start = start_q;
    assign boot.pc    = pc_q;
    assign boot.sp    = sp_q;
    assign boot_done  = (state_q == RVBF_ST_RUN);

    rvbf_vtor u_vtor
    (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .boot_done (boot_done),
        .wr_en     (vtor_wr_en),
        .wr_base   (vtor_wr_base),
        .base      (vtor_base)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_sp_first_addr : assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (flash_req.valid && state_q == RVBF_ST_SP_RQ)
        |-> flash_req.addr == 32'h0000_0000)
        else $error("sp fetch at wrong address");

    chk_pc_fetch_addr : assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (flash_req.valid && state_q == RVBF_ST_PC_RQ)
        |-> flash_req.addr == 32'h0000_0004)
        else $error("pc fetch at wrong address");

    chk_fetch_in_flash : assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        flash_req.valid
        |-> (flash_req.addr & `RVBF_SRAM_MASK) != `RVBF_SRAM_BASE
            && (flash_req.addr & 32'hFFFF_FFF8) == `RVBF_BOOT_BASE)
        else $error("boot fetch left flash");

    chk_sp_loaded : assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (state_q == RVBF_ST_SP_WT && flash_rsp.valid)
        |=> sp_q == $past(flash_rsp.data))
        else $error("stack pointer not loaded");

    chk_start_pc : assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (state_q == RVBF_ST_PC_WT && flash_rsp.valid)
        |=> boot.start && boot.pc == $past(flash_rsp.data))
        else $error("branch not taken to fetched pc");

    chk_start_once : assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        boot.start |=> !boot.start && boot_done)
        else $error("start not a single pulse");

    chk_no_early_start : assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        boot.start |-> $past(state_q) == RVBF_ST_PC_WT)
        else $error("start before both words returned");

    chk_sp_before_pc : assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (state_q == RVBF_ST_PC_RQ) |-> $past(state_q) == RVBF_ST_SP_WT)
        else $error("pc fetch without prior sp fetch");

    chk_single_fetch_pair : assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        boot_done |-> !flash_req.valid)
        else $error("boot fetch after boot done");

    chk_req_one_cycle : assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        flash_req.valid |=> !flash_req.valid)
        else $error("flash request held longer than one cycle");

    chk_done_with_start : assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(boot_done) |-> boot.start)
        else $error("boot done without start pulse");

    chk_vectors_held : assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        boot_done |=> $stable(boot.sp) && $stable(boot.pc))
        else $error("fetched vectors changed after boot");
endmodule : rvbf_top
`default_nettype wire

/* testbench/rvbf_flash_model.sv */
// flash read port model holding the two boot vectors
// assumes one request at a time; lat sets cycles to answer (>=1)
`timescale 1ns/1ps
`default_nettype none
module rvbf_flash_model
#(
    parameter logic [31:0] SP_WORD = 32'h2000_0C00,
    parameter logic [31:0] PC_WORD = 32'h0000_04C1
)
(
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    input  wire rvbf_pkg::rvbf_req_t  req,
    input  wire logic [3:0]           lat,
    input  wire logic                 stray,
    output var  rvbf_pkg::rvbf_rsp_t  rsp
);
    import rvbf_pkg::*;
    logic        busy;
    logic [3:0]  cnt;
    logic [31:0] word;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy <= 1'b0;
            cnt  <= 4'h0;
            word <= 32'h0;
            rsp  <= '0;
        end
        else
        begin
            // data is never left stale once the strobe drops
            rsp.valid <= 1'b0;
            rsp.data  <= ~rsp.data;
            // unsolicited answer; the block must ignore it outside a wait
            if (stray)
            begin
                rsp.valid <= 1'b1;
                rsp.data  <= 32'hA5A5_5A5A;
            end
            if (req.valid)
            begin
                busy <= 1'b1;
                cnt  <= lat;
                // unknown addresses read back garbage, not a vector
                word <= (req.addr == 32'h4) ? PC_WORD :
                        (req.addr == 32'h0) ? SP_WORD : 32'hA5A5_5A5A;
            end
            else if (busy && cnt <= 4'h1)
            begin
                busy      <= 1'b0;
                rsp.valid <= 1'b1;
                rsp.data  <= word;
            end
            else if (busy)
                cnt <= cnt - 4'h1;
        end
    end
endmodule : rvbf_flash_model
`default_nettype wire

/* testbench/tb_top.sv */
// self-checking bench for the boot vector fetch block
// assumes the flash model file is compiled before this one
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rvbf_pkg::*;
    logic        ref_clk, rst_n, vtor_wr_en, boot_done, stray;
    logic [31:0] vtor_wr_base, vtor_base;
    logic [3:0]  lat;
    rvbf_req_t   flash_req;
    rvbf_rsp_t   flash_rsp;
    rvbf_boot_t  boot;
    int          fail_count, tests_run, cycles, n_start;
    logic [31:0] req_log [$];

    rvbf_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .flash_req(flash_req), .flash_rsp(flash_rsp),
        .vtor_wr_en(vtor_wr_en), .vtor_wr_base(vtor_wr_base),
        .vtor_base(vtor_base), .boot(boot), .boot_done(boot_done));
    rvbf_flash_model i_flash (.ref_clk(ref_clk), .rst_n(rst_n),
        .req(flash_req), .lat(lat), .stray(stray), .rsp(flash_rsp));

    always #25 ref_clk = ~ref_clk;

    // --------------------------------------------------------------
    // monitor and watchdog
    // --------------------------------------------------------------
    // sampled mid-cycle since request lines decode straight from state
    always @(negedge ref_clk)
    begin
        if (rst_n && flash_req.valid === 1'b1)
            req_log.push_back(flash_req.addr);
        if (rst_n && boot.start === 1'b1)
            n_start++;
    end

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            close_out();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp)
        begin
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
            fail_count++;
        end
    endtask : check

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic boot_run(input logic [3:0] l);
        int i;
        @(posedge ref_clk);
        rst_n <= 1'b0;
        lat   <= l;
        repeat (10) @(posedge ref_clk);
        req_log.delete();
        n_start = 0;
        rst_n <= 1'b1;
        @(posedge ref_clk);
        // relocation attempt while the fetch is still running
        vtor_wr_en   <= 1'b1;
        vtor_wr_base <= 32'h2000_0100;
        @(posedge ref_clk);
        vtor_wr_en <= 1'b0;
        for (i = 0; i < 200 && boot.start !== 1'b1; i++)
            @(negedge ref_clk);
        check("start cycle", i, 4 + 2 * l);
        check("requests", req_log.size(), 2);
        check("sp addr", req_log[0], 32'h0);
        check("pc addr", req_log[1], 32'h4);
        check("sp", boot.sp, i_flash.SP_WORD);
        check("pc", boot.pc, i_flash.PC_WORD);
        check("done", boot_done, 1'b1);
        check("early base", vtor_base, 32'h0);
        repeat (20) @(negedge ref_clk);
        check("starts", n_start, 1);
        check("late requests", req_log.size(), 2);
    endtask : boot_run

    task automatic relocate();
        @(posedge ref_clk);
        vtor_wr_en   <= 1'b1;
        vtor_wr_base <= 32'h2000_01C4;
        stray        <= 1'b1;
        @(posedge ref_clk);
        vtor_wr_en <= 1'b0;
        stray      <= 1'b0;
        repeat (2) @(negedge ref_clk);
        check("base", vtor_base, 32'h2000_0180);
        check("pc kept", boot.pc, i_flash.PC_WORD);
        check("sp kept", boot.sp, i_flash.SP_WORD);
        check("stray starts", n_start, 1);
        check("no refetch", req_log.size(), 2);
    endtask : relocate

    task automatic close_out();
        if (fail_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    initial
    begin
        ref_clk      = 1'b0;
        rst_n        = 1'b0;
        vtor_wr_en   = 1'b0;
        vtor_wr_base = 32'h0;
        lat          = 4'h1;
        stray        = 1'b0;
        boot_run(4'h1);
        relocate();
        // reset after relocation must fetch from flash base again
        boot_run(4'h7);
        relocate();
        close_out();
    end
endmodule : tb_top
`default_nettype wire
